// file: hdl/refresh_sched_pkg.sv
/*
 * constants, register map, enumerations and carriers shared by the
 * refresh / power-down scheduler and its helper modules.
 * assumes a 32-bit apb register bus on a single 20 mhz clock.
 */
package refresh_sched_pkg;

	// register byte offsets
	localparam logic [11:0] OFS_CTRL     = 12'h000;
	localparam logic [11:0] OFS_INTERVAL = 12'h004;
	localparam logic [11:0] OFS_LATENCY  = 12'h008;
	localparam logic [11:0] OFS_STATUS   = 12'h00C;

	// refresh_control_word fields
	localparam int CTRL_AUTO_REFRESH_ENABLE  = 0;
	localparam int CTRL_BOUNDARY_SELECT      = 1;
	localparam int CTRL_AUTO_LOW_POWER_ENTRY = 2;
	localparam int CTRL_POWER_DOWN_REQUEST   = 3;
	localparam int CTRL_MANUAL_REFRESH       = 8;

	// read_latency_control_word fields
	localparam int LAT_CAS_LSB    = 0;
	localparam int LAT_ADJUST_LSB = 4;
	localparam int LAT_BASE_LSB   = 8;
	localparam int LAT_FIELD_W    = 4;

	// status fields
	localparam int STAT_IN_POWER_DOWN  = 0;
	localparam int STAT_REFRESH_PEND   = 1;
	localparam int STAT_UPDATE_PEND    = 2;
	localparam int STAT_COUNT_LSB      = 16;

	localparam int INTERVAL_W  = 16;
	localparam int BEATS_W     = 8;
	localparam int GUARD_W     = 6;
	localparam int IDLE_W      = 5;

	// reset values
	localparam logic [3:0]            CTRL_RESET     = 4'h1;
	localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 16'h0100;
	localparam logic [11:0]           LATENCY_RESET  = 12'h0033;

	// idle cycles before automatic power-down entry
	localparam logic [IDLE_W-1:0]  IDLE_LIMIT   = 5'h10;
	// extra cycles after the last read word before an update may go out
	localparam logic [GUARD_W-1:0] GUARD_MARGIN = 6'h02;

	// timing of the register bus
	localparam int CLK_PERIOD_NS = 50;

	typedef enum logic [2:0] {
		OP_NOP      = 3'b000,
		OP_READ     = 3'b001,
		OP_WRITE    = 3'b010,
		OP_REFRESH  = 3'b011,
		OP_PD_ENTER = 3'b100,
		OP_PD_EXIT  = 3'b101
	} mem_op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_XFER = 2'b01,
		ST_PD   = 2'b10
	} sched_state_e;

	typedef struct packed {
		logic               valid;
		logic               is_read;
		logic [BEATS_W-1:0] beats;
	} sys_cmd_s;

	typedef struct packed {
		logic    valid;
		mem_op_e op;
	} mem_cmd_s;

	typedef struct packed {
		logic [LAT_FIELD_W-1:0] base_delay;
		logic [LAT_FIELD_W-1:0] adjust;
		logic [LAT_FIELD_W-1:0] cas;
	} latency_s;

endpackage

// file: hdl/refresh_timer.sv
/*
 * automatic refresh down-counter: loads the interval, counts to zero,
 * pulses, reloads.
 * assumes enable and reload come from logic on the same clock.
 */
`timescale 1ns/10ps
module refresh_timer
	import refresh_sched_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  enable,
	input  wire logic                  reload,
	input  wire logic [INTERVAL_W-1:0] interval,
	output logic                       expired,
	output logic [INTERVAL_W-1:0]      count
);
	import refresh_sched_pkg::*;

	logic [INTERVAL_W-1:0] count_ff;
	logic                  expired_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_ff   <= INTERVAL_RESET;
			expired_ff <= 1'b0;
		end
		else
		begin
			expired_ff <= 1'b0;
			if (!enable || reload)
				count_ff <= interval; // [R13]
			else if (count_ff == '0)
			begin
				expired_ff <= 1'b1; // [R11]
				count_ff   <= interval;
			end
			else
				count_ff <= count_ff - 1'b1; // [R11]
		end
	end

	assign expired = expired_ff;
	assign count   = count_ff;

endmodule // refresh_timer

// file: hdl/read_drain_guard.sv
/*
 * tracks outstanding read data: after each accepted read it counts the
 * full return delay before reporting the read path drained.
 * assumes latency settings are static while reads are in flight.
 */
`timescale 1ns/10ps
module read_drain_guard
	import refresh_sched_pkg::*;
(
	input  wire logic     pclk,
	input  wire logic     presetn,
	input  wire logic     read_issued,
	input  wire latency_s latency,
	output logic          drained
);
	import refresh_sched_pkg::*;

	logic [GUARD_W-1:0] wait_ff;
	logic [GUARD_W-1:0] nxt_wait;
	logic               drained_ff;

	// whole return path counted, so adjust above cas cannot shorten it
	assign nxt_wait = GUARD_W'(latency.cas) + GUARD_W'(latency.adjust)
		+ GUARD_W'(latency.base_delay) + GUARD_MARGIN; // [R08]

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_ff    <= '0;
			drained_ff <= 1'b1;
		end
		else if (read_issued)
		begin
			wait_ff    <= nxt_wait; // [R08]
			drained_ff <= 1'b0;
		end
		else if (wait_ff != '0)
		begin
			wait_ff    <= wait_ff - 1'b1;
			drained_ff <= 1'b0;
		end
		else
			drained_ff <= 1'b1;
	end

	assign drained = drained_ff;

endmodule // read_drain_guard

// file: hdl/dram_refresh_powerdown_scheduler.sv
/*
 * refresh scheduling, power-down entry/exit and dfi update timing of a
 * ddr controller, with an apb register file.
 * assumes system commands, phy handshakes and apb all run on pclk.
 */
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
// Behaviour
// [R01] with the boundary select clear a due refresh goes out at the next memory command slot, with it set only between system commands.
// [R02] one system command is split into as many memory commands as its beat count asks for.
// [R03] a manual power-down request overrides the boundary select so a deferred refresh is not held off through power-down.
// [R04] a due refresh is always delivered while the memory is powered down; the scheduler sends it only after it has issued a power-down exit.
// [R05] power-down is entered either on a software request or automatically after idle time, and refreshes keep flowing in both cases.
// [R06] software keeps the read latency adjust no larger than the cas latency.
// [R07] software adds read delay beyond the cas latency through the base delay field.
// [R08] update requests wait until all outstanding read data has returned, whatever adjust is set.
// [R09] software clears the boundary select before manual power-down and may set it again afterwards.
// [R10] a software refresh request during power-down never loses a scheduled refresh.
// [R11] with automatic refresh on, a down-counter reloads from the interval and asks for a refresh at every zero.
// [R12] a refresh due in power-down brings the memory out of power-down first.
// [R13] a software refresh request reloads the automatic refresh counter.
// [R14] after a refresh that needed a power-down exit the memory goes back down if still requested and idle.
module dram_refresh_powerdown_scheduler
	import refresh_sched_pkg::*;
(
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire refresh_sched_pkg::sys_cmd_s sys_cmd,
	output logic                          sys_cmd_ready,
	output refresh_sched_pkg::mem_cmd_s   mem_cmd,
	input  wire logic                     mem_cmd_ready,
	input  wire logic                     update_needed,
	output logic                          dfi_ctrlupd_req,
	input  wire logic                     dfi_ctrlupd_ack
);
	import refresh_sched_pkg::*;

	logic [31:0]           prdata_ff;
	logic                  pready_ff;
	logic                  pslverr_ff;
	logic [3:0]            ctrl_ff;
	logic [INTERVAL_W-1:0] interval_ff;
	logic [11:0]           latency_ff;
	logic                  manual_refresh_ff;
	logic                  refresh_pending_ff;
	logic                  refresh_backlog_ff;
	sched_state_e          state_ff;
	logic [BEATS_W-1:0]    beats_ff;
	logic                  is_read_ff;
	mem_cmd_s              mem_cmd_ff;
	logic                  sys_ready_ff;
	logic                  in_pd_ff;
	logic [IDLE_W-1:0]     idle_ff;
	logic                  upd_req_ff;

	logic                  apb_setup;
	logic                  apb_write;
	logic                  mapped;
	logic [31:0]           read_word;
	logic                  timer_expired;
	logic [INTERVAL_W-1:0] timer_count;
	logic                  accepted;
	logic                  cmd_free;
	logic                  refresh_done;
	logic                  read_done;
	logic                  refresh_due;
	logic                  pd_request;
	logic                  defer_select;
	logic                  pd_want;
	logic                  drained;
	latency_s              latency;

	assign latency = latency_s'(latency_ff);

	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pready_ff && pwrite;
	assign mapped    = (paddr == OFS_CTRL) || (paddr == OFS_INTERVAL)
		|| (paddr == OFS_LATENCY) || (paddr == OFS_STATUS);

	always_comb
	begin
		read_word = '0;
		case (paddr)
			OFS_CTRL:     read_word[3:0] = ctrl_ff;
			OFS_INTERVAL: read_word[INTERVAL_W-1:0] = interval_ff;
			OFS_LATENCY:  read_word[11:0] = latency_ff;
			OFS_STATUS:
			begin
				read_word[STAT_IN_POWER_DOWN] = in_pd_ff;
				read_word[STAT_REFRESH_PEND]  = refresh_pending_ff;
				read_word[STAT_UPDATE_PEND]   = upd_req_ff;
				read_word[STAT_COUNT_LSB +: INTERVAL_W] = timer_count;
			end
			default:      read_word = '0;
		endcase
	end

	// zero-wait slave: answer raised during the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end
		else
		begin
			pready_ff  <= apb_setup;
			pslverr_ff <= apb_setup && !mapped;
			if (apb_setup && !pwrite)
				prdata_ff <= read_word;
		end
	end

	// status is read-only; unmapped writes are dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff     <= CTRL_RESET;
			interval_ff <= INTERVAL_RESET;
			latency_ff  <= LATENCY_RESET;
		end
		else if (apb_write)
		begin
			if (paddr == OFS_CTRL)
				ctrl_ff <= pwdata[3:0];
			if (paddr == OFS_INTERVAL)
				interval_ff <= pwdata[INTERVAL_W-1:0];
			if (paddr == OFS_LATENCY)
				latency_ff <= pwdata[11:0];
		end
	end

	// write-one pulse, reads back as zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			manual_refresh_ff <= 1'b0;
		else
			manual_refresh_ff <= apb_write && (paddr == OFS_CTRL)
				&& pwdata[CTRL_MANUAL_REFRESH];
	end

	refresh_timer u_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.enable   (ctrl_ff[CTRL_AUTO_REFRESH_ENABLE]),
		.reload   (manual_refresh_ff), // [R13]
		.interval (interval_ff),
		.expired  (timer_expired),
		.count    (timer_count)
	);

	assign accepted     = mem_cmd_ff.valid && mem_cmd_ready;
	assign cmd_free     = !mem_cmd_ff.valid || mem_cmd_ready;
	assign refresh_done = accepted && (mem_cmd_ff.op == OP_REFRESH);
	assign read_done    = accepted && (mem_cmd_ff.op == OP_READ);
	// the refresh taken at this edge is not owed any more
	assign refresh_due  = refresh_pending_ff && !refresh_done;

	// a manual request is kept as its own pending refresh while the
	// counter reloads, so the scheduled one it displaces is not lost
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			refresh_pending_ff <= 1'b0;
		else if (timer_expired || manual_refresh_ff
			|| refresh_backlog_ff)
			refresh_pending_ff <= 1'b1; // [R10] [R11]
		else if (refresh_done)
			refresh_pending_ff <= 1'b0;
	end

	// a second event while one is still owed is parked, not merged
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			refresh_backlog_ff <= 1'b0;
		else if ((timer_expired && manual_refresh_ff)
			|| ((timer_expired || manual_refresh_ff) && refresh_due))
			refresh_backlog_ff <= 1'b1; // [R10]
		else if (refresh_done)
			refresh_backlog_ff <= refresh_backlog_ff
				&& (timer_expired || manual_refresh_ff);
	end

	assign pd_request   = ctrl_ff[CTRL_POWER_DOWN_REQUEST];
	assign defer_select = ctrl_ff[CTRL_BOUNDARY_SELECT] && !pd_request; // [R03]
	assign pd_want      = pd_request
		|| (ctrl_ff[CTRL_AUTO_LOW_POWER_ENTRY] && (idle_ff == IDLE_LIMIT)); // [R05]

	// idle time before automatic entry; saturates at IDLE_LIMIT, cleared by a system command
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			idle_ff <= '0;
		else if (sys_cmd.valid || (state_ff == ST_XFER))
			idle_ff <= '0;
		else if (idle_ff != IDLE_LIMIT)
			idle_ff <= idle_ff + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff     <= ST_IDLE;
			beats_ff     <= '0;
			is_read_ff   <= 1'b0;
			mem_cmd_ff   <= '{valid: 1'b0, op: OP_NOP};
			sys_ready_ff <= 1'b0;
			in_pd_ff     <= 1'b0;
		end
		else
		begin
			sys_ready_ff <= 1'b0;
			if (accepted)
				mem_cmd_ff <= '{valid: 1'b0, op: OP_NOP};
			case (state_ff)
				ST_IDLE:
				begin
					if (cmd_free)
					begin
						if (refresh_due)
							mem_cmd_ff <= '{valid: 1'b1, op: OP_REFRESH}; // [R01]
						else if (sys_cmd.valid && !sys_ready_ff)
						begin
							sys_ready_ff <= 1'b1;
							beats_ff     <= sys_cmd.beats; // [R02]
							is_read_ff   <= sys_cmd.is_read;
							state_ff     <= ST_XFER;
						end
						else if (pd_want)
						begin
							mem_cmd_ff <= '{valid: 1'b1, op: OP_PD_ENTER}; // [R05] [R14]
							in_pd_ff   <= 1'b1;
							state_ff   <= ST_PD;
						end
					end
				end
				ST_XFER:
				begin
					if (cmd_free)
					begin
						if (beats_ff == '0)
							state_ff <= ST_IDLE;
						else if (refresh_due && !defer_select)
							mem_cmd_ff <= '{valid: 1'b1, op: OP_REFRESH}; // [R01]
						else if (!(is_read_ff && upd_req_ff))
						begin
							mem_cmd_ff <= '{valid: 1'b1,
								op: is_read_ff ? OP_READ : OP_WRITE}; // [R02]
							beats_ff   <= beats_ff - 1'b1;
						end
					end
				end
				ST_PD:
				begin
					if (cmd_free && (refresh_pending_ff || sys_cmd.valid
						|| !pd_want))
					begin
						mem_cmd_ff <= '{valid: 1'b1, op: OP_PD_EXIT}; // [R04] [R12]
						in_pd_ff   <= 1'b0;
						state_ff   <= ST_IDLE;
					end
				end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

	read_drain_guard u_guard (
		.pclk        (pclk),
		.presetn     (presetn),
		.read_issued (read_done),
		.latency     (latency),
		.drained     (drained)
	);

	// request held until acknowledged; reads stall meanwhile
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			upd_req_ff <= 1'b0;
		else if (upd_req_ff)
		begin
			if (dfi_ctrlupd_ack)
				upd_req_ff <= 1'b0;
		end
		else if (update_needed && drained && !read_done
			&& !(mem_cmd_ff.valid && (mem_cmd_ff.op == OP_READ)))
			upd_req_ff <= 1'b1; // [R08]
	end

	assign prdata          = prdata_ff;
	assign pready          = pready_ff;
	assign pslverr         = pslverr_ff;
	assign sys_cmd_ready   = sys_ready_ff;
	assign mem_cmd         = mem_cmd_ff;
	assign dfi_ctrlupd_req = upd_req_ff;

endmodule // dram_refresh_powerdown_scheduler

// file: tb/ddr_phy_model.sv
/*
 * phy and memory model: accepts memory commands, tracks power-down,
 * counts refreshes and data beats, acknowledges update requests.
 * assumes commands arrive on pclk from the scheduler under test.
 */
`timescale 1ns/10ps
module ddr_phy_model
	import refresh_sched_pkg::*;
(
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        slow,
	input  wire refresh_sched_pkg::mem_cmd_s mem_cmd,
	output logic                             mem_cmd_ready,
	input  wire logic                        dfi_ctrlupd_req,
	output logic                             dfi_ctrlupd_ack,
	output int                               n_ref,
	output int                               n_rw,
	output int                               n_bad,
	output logic                             in_pd
);
	logic acc;
	mem_op_e op;
	assign acc = mem_cmd.valid && mem_cmd_ready;
	assign op = mem_cmd.op;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mem_cmd_ready <= 1'b0;
			dfi_ctrlupd_ack <= 1'b0;
			n_ref <= 0;
			n_rw <= 0;
			n_bad <= 0;
			in_pd <= 1'b0;
		end
		else
		begin
			mem_cmd_ready <= slow ? ~mem_cmd_ready : 1'b1;
			dfi_ctrlupd_ack <= dfi_ctrlupd_req && !dfi_ctrlupd_ack;
			if (acc && op == OP_REFRESH)
				n_ref <= n_ref + 1;
			if (acc && (op == OP_READ || op == OP_WRITE))
				n_rw <= n_rw + 1;
			// a sleeping device takes nothing but an exit
			if (acc && in_pd && op != OP_PD_EXIT)
				n_bad <= n_bad + 1;
			if (acc && op == OP_PD_ENTER)
				in_pd <= 1'b1;
			if (acc && op == OP_PD_EXIT)
				in_pd <= 1'b0;
		end
endmodule // ddr_phy_model

// file: tb/dram_refresh_powerdown_scheduler_asserts.sv
/*
 * port checker for the refresh scheduler.
 * assumes latency stays at or above its reset value.
 */
`timescale 1ns/10ps
module dram_refresh_powerdown_scheduler_asserts
	import refresh_sched_pkg::*;
(
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [11:0]                 paddr,
	input wire logic [31:0]                 pwdata,
	input wire logic [31:0]                 prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire refresh_sched_pkg::sys_cmd_s sys_cmd,
	input wire logic                        sys_cmd_ready,
	input wire refresh_sched_pkg::mem_cmd_s mem_cmd,
	input wire logic                        mem_cmd_ready,
	input wire logic                        update_needed,
	input wire logic                        dfi_ctrlupd_req,
	input wire logic                        dfi_ctrlupd_ack
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc, rw_acc, ref_acc, wr, en_ff, sel_ff, pdr_ff, isrd_ff;
	logic [7:0] left_ff;
	logic [15:0] intv_ff;
	logic [11:0] gap_ff, rgap_ff;
	assign acc = mem_cmd.valid && mem_cmd_ready;
	assign rw_acc = acc && mem_cmd.op inside {OP_READ, OP_WRITE};
	assign ref_acc = acc && mem_cmd.op == OP_REFRESH;
	assign wr = psel && penable && pready && pwrite;
	// shadow of control and interval writes
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{en_ff, sel_ff, pdr_ff, intv_ff} <= {3'b100, INTERVAL_RESET};
		else if (wr && paddr == OFS_CTRL)
			{pdr_ff, sel_ff, en_ff} <= {pwdata[3], pwdata[1:0]};
		else if (wr && paddr == OFS_INTERVAL)
			intv_ff <= pwdata[15:0];
	// beats still owed by the current system command
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{left_ff, isrd_ff} <= '0;
		else if (sys_cmd_ready)
			{left_ff, isrd_ff} <= {sys_cmd.beats, sys_cmd.is_read};
		else if (rw_acc)
			left_ff <= left_ff - 8'h01;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{gap_ff, rgap_ff} <= {12'h000, 12'hFFF};
		else
		begin
			gap_ff <= ref_acc ? 12'h000 : gap_ff + {11'h0, ~&gap_ff};
			if (acc && mem_cmd.op == OP_READ)
				rgap_ff <= 12'h000;
			else if (~&rgap_ff)
				rgap_ff <= rgap_ff + 12'h001;
		end
	property p_beats_done;
		sys_cmd_ready |-> left_ff == 8'h00;
	endproperty
	a_beats_done: assert property (p_beats_done)
		else $error("new command before beats done");
	property p_beats_only;
		rw_acc |-> left_ff != 8'h00;
	endproperty
	a_beats_only: assert property (p_beats_only)
		else $error("data command beyond beat count");
	property p_op_match;
		rw_acc |-> mem_cmd.op == (isrd_ff ? OP_READ : OP_WRITE);
	endproperty
	a_op_match: assert property (p_op_match)
		else $error("data command direction wrong");
	property p_ready_pulse;
		sys_cmd_ready |=> !sys_cmd_ready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("command ready longer than one cycle");
	property p_boundary;
		ref_acc && sel_ff && !pdr_ff |-> left_ff == 8'h00;
	endproperty
	a_boundary: assert property (p_boundary)
		else $error("refresh inside a system command");
	property p_ref_flow;
		en_ff |-> gap_ff <= intv_ff + 16'd64;
	endproperty
	a_ref_flow: assert property (p_ref_flow)
		else $error("refresh overdue");
	property p_upd_guard;
		$rose(dfi_ctrlupd_req) |-> rgap_ff >= 12'd7;
	endproperty
	a_upd_guard: assert property (p_upd_guard)
		else $error("update request before read data drained");
	property p_req_hold;
		dfi_ctrlupd_req && !dfi_ctrlupd_ack |=> dfi_ctrlupd_req;
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("update request dropped before ack");
	property p_req_clr;
		dfi_ctrlupd_req && dfi_ctrlupd_ack |=> !dfi_ctrlupd_req;
	endproperty
	a_req_clr: assert property (p_req_clr)
		else $error("update request kept after ack");
endmodule // dram_refresh_powerdown_scheduler_asserts

// file: tb/dram_refresh_powerdown_scheduler_test.sv
/*
 * self-checking bench: apb and system command tasks, phy model.
 * assumes the scheduler, its package and the checker are compiled first.
 */
`timescale 1ns/10ps
module dram_refresh_powerdown_scheduler_test;
	import refresh_sched_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
	logic        pwrite = 0, update_needed = 0, slow = 0, rerr;
	logic        pready, pslverr, sys_cmd_ready, mem_cmd_ready;
	logic        dfi_ctrlupd_req, dfi_ctrlupd_ack, in_pd;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdat;
	sys_cmd_s    sys_cmd = '0;
	mem_cmd_s    mem_cmd;
	int          n_errors = 0, tests_run = 0, b, w, n_ref, n_rw, n_bad;
	always #25 pclk = ~pclk;
	dram_refresh_powerdown_scheduler dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sys_cmd(sys_cmd), .sys_cmd_ready(sys_cmd_ready),
		.mem_cmd(mem_cmd), .mem_cmd_ready(mem_cmd_ready),
		.update_needed(update_needed), .dfi_ctrlupd_req(dfi_ctrlupd_req),
		.dfi_ctrlupd_ack(dfi_ctrlupd_ack));
	ddr_phy_model phy_u (.pclk(pclk), .presetn(presetn), .slow(slow),
		.mem_cmd(mem_cmd), .mem_cmd_ready(mem_cmd_ready),
		.dfi_ctrlupd_req(dfi_ctrlupd_req),
		.dfi_ctrlupd_ack(dfi_ctrlupd_ack), .n_ref(n_ref), .n_rw(n_rw),
		.n_bad(n_bad), .in_pd(in_pd));
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task tick(input int lim);
		@(posedge pclk);
		if (++w > lim)
		begin
			chk(32'h0, 32'h1);
			test_done();
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		w = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			tick(8);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task sys_op(input logic r, input logic [7:0] n);
		w = 0;
		sys_cmd <= {1'b1, r, n};
		do
			tick(300);
		while (sys_cmd_ready !== 1'b1);
		sys_cmd <= '0;
		@(posedge pclk);
	endtask
	task rng(input int lo, input int hi);
		chk(n_ref - b >= lo && n_ref - b <= hi, 1);
		b = n_ref;
	endtask
	// a refresh leaves power-down for a few cycles; wait out that gap
	task wait_pd(input logic v);
		w = 0;
		while (in_pd !== v)
			tick(12);
		chk(in_pd, v);
	endtask
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, OFS_CTRL, 0);
		chk(rdat, 32'h0000_0001);
		apb(0, OFS_INTERVAL, 0);
		chk(rdat, 32'h0000_0100);
		apb(0, OFS_LATENCY, 0);
		chk(rdat, 32'h0000_0033);
		apb(0, 12'h010, 0);
		chk(rerr, 1);
		apb(1, OFS_INTERVAL, 32'h0000_0008);
		// the counter only takes a new interval when it reloads
		apb(1, OFS_CTRL, 32'h0000_0101);
		b = n_ref;
		repeat (200) @(posedge pclk);
		rng(15, 23);
		$display("test interval done");
		apb(1, OFS_CTRL, 32'h0000_0003);
		for (int s = 0; s < 2; s++)
		begin
			slow <= s[0];
			b = n_rw;
			sys_op(1, 3);
			sys_op(0, 2);
			sys_op(1, 0);
			repeat (20) @(posedge pclk);
			chk(n_rw - b, 5);
		end
		slow <= 1'b0;
		$display("test split done");
		sys_op(0, 8);
		apb(1, OFS_CTRL, 32'h0000_000B);
		b = n_ref;
		repeat (200) @(posedge pclk);
		rng(12, 23);
		wait_pd(1);
		for (int i = 0; i < 10; i++)
		begin
			repeat (5) @(posedge pclk);
			apb(1, OFS_CTRL, 32'h0000_010B);
		end
		// let the last forced refresh go out before counting
		repeat (10) @(posedge pclk);
		rng(10, 25);
		apb(1, OFS_CTRL, 32'h0000_0001);
		repeat (20) @(posedge pclk);
		chk(in_pd, 0);
		$display("test power-down done");
		apb(1, OFS_CTRL, 32'h0000_0007);
		repeat (60) @(posedge pclk);
		wait_pd(1);
		b = n_ref;
		repeat (200) @(posedge pclk);
		rng(12, 23);
		b = n_rw;
		sys_op(1, 2);
		repeat (20) @(posedge pclk);
		chk(n_rw - b, 2);
		$display("test auto low power done");
		apb(1, OFS_CTRL, 32'h0000_0001);
		apb(1, OFS_LATENCY, 32'h0000_0233);
		b = n_rw;
		sys_op(1, 4);
		update_needed <= 1'b1;
		w = 0;
		do
			tick(100);
		while (dfi_ctrlupd_req !== 1'b1);
		update_needed <= 1'b0;
		repeat (5) @(posedge pclk);
		chk(n_rw - b, 4);
		chk(dfi_ctrlupd_req, 0);
		chk(n_bad, 0);
		$display("test update done");
		test_done();
	end
endmodule // dram_refresh_powerdown_scheduler_test
bind dram_refresh_powerdown_scheduler
	dram_refresh_powerdown_scheduler_asserts chk_u (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sys_cmd(sys_cmd), .sys_cmd_ready(sys_cmd_ready),
	.mem_cmd(mem_cmd), .mem_cmd_ready(mem_cmd_ready),
	.update_needed(update_needed), .dfi_ctrlupd_req(dfi_ctrlupd_req),
	.dfi_ctrlupd_ack(dfi_ctrlupd_ack));
